// >>> design/scc_pkg.sv
// Shared constants and types for the sleep and clock divider control block
package scc_pkg;

    // ****************************************
    // Divider select codes
    // ****************************************
    localparam logic [3:0] DIV_SEL_RESET_PLAIN = 4'h0;
    localparam logic [3:0] DIV_SEL_RESET_DIV8 = 4'h3;
    localparam logic [3:0] DIV_SEL_MAX = 4'h8;

    // ****************************************
    // Sleep mode select codes
    // ****************************************
    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_QUIET = 3'h1;
    localparam logic [2:0] MODE_PWR_DOWN = 3'h2;
    localparam logic [2:0] MODE_PWR_SAVE = 3'h3;
    localparam logic [2:0] MODE_STANDBY = 3'h6;
    localparam logic [2:0] MODE_EXT_STANDBY = 3'h7;

    // ****************************************
    // Control register layout
    // ****************************************
    localparam int MON_SLEEP_OFF_BIT = 6;
    localparam logic MON_SLEEP_OFF_RESET = 1'b0;

    // ****************************************
    // Timing
    // ****************************************
    localparam int SYS_CLK_PERIOD_NS = 20;
    localparam int MON_WAKE_NS = 60000;
    localparam int MON_WAKE_CYCLES = (MON_WAKE_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int STANDBY_WAKE_CYCLES = 6;
    localparam int CORE_HOLD_CYCLES = 4;
    localparam int NO_STARTUP_CYCLES = 1;
    localparam int DELAY_W = 16;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_SLEEP = 2'b01,
        ST_START = 2'b10,
        ST_HOLD = 2'b11
    } scc_state_t;

    typedef struct packed {
        logic ext_reset;
        logic wdt_reset;
        logic monitor_reset;
        logic wdt_irq;
        logic tw_addr_match;
        logic tw_irq;
        logic timer2_irq;
        logic conv_done;
        logic spm_ready;
        logic [2:0] ext_irq;
        logic ext0_level;
        logic pin_change;
        logic other_io;
    } scc_wake_t;

    typedef struct packed {
        logic core;
        logic flash;
        logic io;
        logic adc;
        logic asy;
        logic main_osc;
        logic timer_osc;
    } scc_clk_t;

endpackage

// >>> design/scc_clk_div.sv
// Glitch-free power-of-two divider producing a clock-enable tick
module scc_clk_div (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic [3:0] i_sel,
    output logic o_tick
);
    import scc_pkg::*;

    logic [7:0] cnt_r;
    logic [3:0] act_r;
    logic [7:0] mask;
    logic tick_nxt;

    // Reserved codes run at the slowest factor rather than an undefined one
    always_comb begin
        mask = 8'hFF;
        if (act_r <= DIV_SEL_MAX) begin
            mask = 8'((9'h001 << act_r) - 9'h001);
        end
        tick_nxt = ((cnt_r & mask) == mask);
    end

    // New factor is only taken at a period boundary so no short pulse appears
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            cnt_r <= 8'h00;
            // Follow the fuse-loaded select so no fast tick leaks out after reset
            act_r <= i_sel;
        end else begin
            cnt_r <= tick_nxt ? 8'h00 : 8'(cnt_r + 8'h01);
            if (tick_nxt) begin
                act_r <= i_sel;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            o_tick <= 1'b0;
        end else begin
            o_tick <= tick_nxt;
        end
    end

endmodule

// >>> design/scc_delay.sv
// Loadable down counter that pulses once when a delay has elapsed
module scc_delay #(
    parameter int W = 16
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_load,
    input wire logic [W-1:0] i_count,
    output logic o_done
);
    logic [W-1:0] cnt_r;

    if (W < 2 || W > 24) begin : g_chk
        $error("scc_delay width out of range");
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            cnt_r <= '0;
        end else if (i_load) begin
            cnt_r <= i_count;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            o_done <= 1'b0;
        end else begin
            o_done <= !i_load && (cnt_r == W'(1));
        end
    end

endmodule

// >>> design/scc_top.sv
// Sleep entry, clock domain gating, monitor sleep-off and wake sequencing
// ****************************************
// Summary of operation
// - Reset divider select from divide-by-eight fuse
// - Any divider select write is accepted
// - Divide by two to the select power, by 256 for codes above 8
// - Sleep only on instruction with allow set
// - Codes 000/001/010 are idle/quiet/power-down
// - Interrupt wake holds core four extra cycles
// - Register file and SRAM kept across sleep
// - Reset during sleep restarts at reset vector
// - Control bit 6 turns monitor off, reset zero
// - Monitor off only in deep sleep modes
// - Monitor off after entry, back on wake
// - Monitor-off wake lasts at least 60 us
// - Idle stops only core and program memory
// - Quiet mode also stops peripheral clock
// - Idle/quiet entry starts conversion when enabled
// - Quiet mode wakes on its listed sources
// - Power-down halts oscillator and all clocks
// - Power-down wakes only on async sources
// - Power-down wake waits clock source start-up
// - Save/extended keep async timer clock if async
// - Code 011 is power-save, timer 2 wakes
// - 110/111 standby modes, six cycle wake
// ****************************************
module scc_top #(
    parameter int PD_STARTUP_CYCLES = 16384
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_divide_by_eight_fuse,
    input wire logic i_div_wr,
    input wire logic [3:0] i_div_wdata,
    input wire logic i_sleep_allow,
    input wire logic [2:0] i_sleep_mode_select,
    input wire logic i_sleep_instr,
    input wire logic i_mcu_ctrl_wr,
    input wire logic [7:0] i_mcu_ctrl_wdata,
    input wire logic i_mcu_ctrl_unlock,
    input wire logic i_crystal_clock,
    input wire logic i_timer2_async,
    input wire logic i_converter_enable,
    input wire scc_pkg::scc_wake_t i_wake,
    output logic [3:0] o_clock_divider_select,
    output logic o_div_tick,
    output scc_pkg::scc_clk_t o_clk_en,
    output logic o_monitor_sleep_off,
    output logic o_monitor_on,
    output logic o_sleeping,
    output logic o_core_hold,
    output logic o_start_conversion,
    output logic o_resume,
    output logic o_reset_vector
);
    import scc_pkg::*;

    if (PD_STARTUP_CYCLES < 1 || PD_STARTUP_CYCLES >= (1 << DELAY_W)) begin : g_chk
        $error("PD_STARTUP_CYCLES out of range");
    end

    // ****************************************
    // Declarations
    // ****************************************
    scc_state_t state_r;
    logic [2:0] mode_r;
    logic mon_off_r;
    logic from_reset_r;
    logic [1:0] hold_r;
    logic mode_ok;
    logic enter;
    logic mon_eligible;
    logic wake_any;
    logic wake_rst;
    logic load;
    logic done;
    logic [DELAY_W-1:0] start_cnt;
    scc_wake_t wmask;
    scc_clk_t clk_nxt;

    // ****************************************
    // Divider select
    // ****************************************
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            o_clock_divider_select <= i_divide_by_eight_fuse ? DIV_SEL_RESET_DIV8
                                                             : DIV_SEL_RESET_PLAIN;
        end else if (i_div_wr) begin
            o_clock_divider_select <= i_div_wdata;
        end
    end

    scc_clk_div u_div (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_sel(o_clock_divider_select),
        .o_tick(o_div_tick)
    );

    // ****************************************
    // Monitor sleep-off control bit
    // ****************************************
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            o_monitor_sleep_off <= MON_SLEEP_OFF_RESET;
        end else if (i_mcu_ctrl_wr && i_mcu_ctrl_unlock) begin
            // A write without the unlock leaves the bit alone
            o_monitor_sleep_off <= i_mcu_ctrl_wdata[MON_SLEEP_OFF_BIT];
        end
    end

    // ****************************************
    // Mode decode and wake source masks
    // ****************************************
    always_comb begin
        mode_ok = 1'b0;
        mon_eligible = 1'b0;
        case (i_sleep_mode_select)
            MODE_IDLE, MODE_QUIET: mode_ok = 1'b1;
            MODE_PWR_DOWN, MODE_PWR_SAVE: begin
                mode_ok = 1'b1;
                mon_eligible = 1'b1;
            end
            MODE_STANDBY, MODE_EXT_STANDBY: begin
                // Standby needs a crystal; otherwise treated as reserved
                mode_ok = i_crystal_clock;
                mon_eligible = 1'b1;
            end
            default: mode_ok = 1'b0;
        endcase
    end

    assign enter = (state_r == ST_RUN) && i_sleep_instr && i_sleep_allow && mode_ok;

    always_comb begin
        wmask = '0;
        wmask.ext_reset = 1'b1;
        wmask.wdt_reset = 1'b1;
        wmask.monitor_reset = 1'b1;
        wmask.wdt_irq = 1'b1;
        wmask.tw_addr_match = 1'b1;
        // Level sources are sampled here; a short pulse may be missed
        wmask.ext0_level = 1'b1;
        wmask.ext_irq = 3'b110;
        wmask.pin_change = 1'b1;
        case (mode_r)
            MODE_IDLE: wmask = '1;
            MODE_QUIET: begin
                wmask.tw_irq = 1'b1;
                wmask.timer2_irq = 1'b1;
                wmask.conv_done = 1'b1;
                wmask.spm_ready = 1'b1;
            end
            MODE_PWR_SAVE, MODE_EXT_STANDBY: wmask.timer2_irq = 1'b1;
            MODE_PWR_DOWN, MODE_STANDBY: wmask.timer2_irq = 1'b0;
            default: wmask.other_io = 1'b0;
        endcase
    end

    assign wake_rst = i_wake.ext_reset | i_wake.wdt_reset | i_wake.monitor_reset;
    assign wake_any = (state_r == ST_SLEEP) && (|(i_wake & wmask));
    assign load = wake_any;

    // ****************************************
    // Start-up time selection
    // ****************************************
    always_comb begin
        case (mode_r)
            MODE_PWR_DOWN, MODE_PWR_SAVE: start_cnt = DELAY_W'(PD_STARTUP_CYCLES);
            MODE_STANDBY, MODE_EXT_STANDBY: start_cnt = DELAY_W'(STANDBY_WAKE_CYCLES);
            default: start_cnt = DELAY_W'(NO_STARTUP_CYCLES);
        endcase
        if (mon_off_r && start_cnt < DELAY_W'(MON_WAKE_CYCLES)) begin
            start_cnt = DELAY_W'(MON_WAKE_CYCLES);
        end
    end

    scc_delay #(
        .W(DELAY_W)
    ) u_start (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_load(load),
        .i_count(start_cnt),
        .o_done(done)
    );

    // ****************************************
    // Sleep sequencer
    // ****************************************
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            state_r <= ST_RUN;
            hold_r <= 2'h0;
        end else begin
            case (state_r)
                ST_RUN: if (enter) begin
                    state_r <= ST_SLEEP;
                end
                ST_SLEEP: if (wake_any) begin
                    state_r <= ST_START;
                end
                ST_START: if (done) begin
                    state_r <= ST_HOLD;
                    hold_r <= 2'h0;
                end
                ST_HOLD: begin
                    hold_r <= 2'(hold_r + 2'h1);
                    if (hold_r == 2'(CORE_HOLD_CYCLES - 1)) begin
                        state_r <= ST_RUN;
                    end
                end
                default: state_r <= ST_RUN;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            mode_r <= MODE_IDLE;
            mon_off_r <= 1'b0;
            from_reset_r <= 1'b0;
        end else if (enter) begin
            mode_r <= i_sleep_mode_select;
            mon_off_r <= o_monitor_sleep_off && mon_eligible;
            from_reset_r <= 1'b0;
        end else if (wake_any) begin
            from_reset_r <= wake_rst;
        end
    end

    // ****************************************
    // Clock domains and status outputs
    // ****************************************
    always_comb begin
        clk_nxt = '1;
        clk_nxt.asy = i_timer2_async;
        clk_nxt.timer_osc = i_timer2_async;
        if (state_r == ST_SLEEP && !wake_any || enter) begin
            clk_nxt = '0;
            case (enter ? i_sleep_mode_select : mode_r)
                MODE_IDLE: begin
                    clk_nxt = '1;
                    clk_nxt.core = 1'b0;
                    clk_nxt.flash = 1'b0;
                    clk_nxt.timer_osc = i_timer2_async;
                end
                MODE_QUIET: begin
                    clk_nxt.adc = 1'b1;
                    clk_nxt.asy = 1'b1;
                    clk_nxt.main_osc = 1'b1;
                    clk_nxt.timer_osc = i_timer2_async;
                end
                MODE_PWR_SAVE: begin
                    clk_nxt.asy = i_timer2_async;
                    clk_nxt.timer_osc = i_timer2_async;
                end
                MODE_STANDBY: clk_nxt.main_osc = 1'b1;
                MODE_EXT_STANDBY: begin
                    clk_nxt.main_osc = 1'b1;
                    clk_nxt.asy = i_timer2_async;
                    clk_nxt.timer_osc = i_timer2_async;
                end
                default: clk_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            o_clk_en <= '1;
            o_sleeping <= 1'b0;
            o_core_hold <= 1'b0;
        end else begin
            o_clk_en <= clk_nxt;
            o_sleeping <= enter || (state_r == ST_SLEEP && !wake_any);
            // Core is only stalled, never reset, so its state survives
            o_core_hold <= enter || (state_r != ST_RUN) &&
                           !(state_r == ST_HOLD && hold_r == 2'(CORE_HOLD_CYCLES - 1));
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            o_monitor_on <= 1'b1;
        end else begin
            // Off only after entry; back on as soon as the wake begins
            o_monitor_on <= !(state_r == ST_SLEEP && mon_off_r && !wake_any);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            o_start_conversion <= 1'b0;
            o_resume <= 1'b0;
            o_reset_vector <= 1'b0;
        end else begin
            o_start_conversion <= enter && i_converter_enable &&
                                  (i_sleep_mode_select == MODE_IDLE ||
                                   i_sleep_mode_select == MODE_QUIET);
            o_resume <= state_r == ST_HOLD && hold_r == 2'(CORE_HOLD_CYCLES - 1) && !from_reset_r;
            o_reset_vector <= state_r == ST_HOLD && hold_r == 2'(CORE_HOLD_CYCLES - 1) &&
                              from_reset_r;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    property p_reset_sel;
        @(posedge i_sys_clk) $rose(i_reset_n) |->
            o_clock_divider_select == ($past(i_divide_by_eight_fuse) ? DIV_SEL_RESET_DIV8
                                                                     : DIV_SEL_RESET_PLAIN);
    endproperty
    a_reset_sel: assert property (p_reset_sel) else $error("bad divider reset value");

    property p_div_write;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
            i_div_wr |=> o_clock_divider_select == $past(i_div_wdata);
    endproperty
    a_div_write: assert property (p_div_write) else $error("divider write lost");

    property p_div_one;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
            o_div_tick && $past(o_clock_divider_select) == 4'h0 |=> o_div_tick;
    endproperty
    a_div_one: assert property (p_div_one) else $error("factor one not every cycle");

    property p_no_sleep;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
            state_r == ST_RUN && !(i_sleep_instr && i_sleep_allow) |=> !o_sleeping;
    endproperty
    a_no_sleep: assert property (p_no_sleep) else $error("sleep without permission");

    property p_hold4;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
            $rose(state_r == ST_HOLD) |-> (o_core_hold && state_r == ST_HOLD) [*4]
                ##1 (state_r == ST_RUN && (o_resume || o_reset_vector));
    endproperty
    a_hold4: assert property (p_hold4) else $error("core hold not four cycles");

    property p_mon_light;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
            o_sleeping && (mode_r == MODE_IDLE || mode_r == MODE_QUIET) |-> o_monitor_on;
    endproperty
    a_mon_light: assert property (p_mon_light) else $error("monitor off in light sleep");

    property p_mon_back;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
            wake_any |=> o_monitor_on && o_core_hold;
    endproperty
    a_mon_back: assert property (p_mon_back) else $error("monitor not back on wake");

    property p_standby_wake;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
            wake_any && mode_r == MODE_STANDBY && !mon_off_r |->
                ##11 o_core_hold ##1 !o_core_hold;
    endproperty
    a_standby_wake: assert property (p_standby_wake) else $error("standby wake time");

    property p_conv;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
            enter && i_converter_enable && i_sleep_mode_select == MODE_QUIET |=>
                o_start_conversion && !o_clk_en.io && o_clk_en.adc;
    endproperty
    a_conv: assert property (p_conv) else $error("quiet entry wrong");

    c_pd: cover property (@(posedge i_sys_clk) enter && i_sleep_mode_select == MODE_PWR_DOWN);
    c_mon: cover property (@(posedge i_sys_clk) wake_any && mon_off_r);
    c_rst: cover property (@(posedge i_sys_clk) o_reset_vector);

endmodule

// >>> tb/scc_core_model.sv
// Behavioural core and wake-source model facing the sleep controller
module scc_core_model (
    input wire logic i_sys_clk,
    input wire logic i_core_hold,
    input wire logic i_cmd_sleep,
    input wire scc_pkg::scc_wake_t i_cmd_wake,
    output logic o_sleep_instr,
    output scc_pkg::scc_wake_t o_wake
);
    import scc_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic hold_d_r = 1'b0;
    initial begin
        o_sleep_instr = 1'b0;
        o_wake = '0;
    end
    always @(posedge i_sys_clk) begin
        hold_d_r <= i_core_hold;
        // A new sleep waits until the core runs again
        o_sleep_instr <= #1 i_cmd_sleep && !i_core_hold;
        // Level requests stay up until the core is released
        if (hold_d_r && !i_core_hold) begin
            o_wake <= #1 '0;
        end else begin
            o_wake <= #1 o_wake | i_cmd_wake;
        end
    end
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the sleep and clock divider controller
module tb_top;
    import scc_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_sys_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic fuse = 1'b1;
    logic div_wr = 1'b0;
    logic [3:0] div_wd = 4'h0;
    logic allow = 1'b0;
    logic [2:0] mode = 3'h0;
    logic ctl_wr = 1'b0;
    logic [7:0] ctl_wd = 8'h00;
    logic unlock = 1'b0;
    logic t2a = 1'b0;
    logic conv_en = 1'b0;
    logic cmd_sleep = 1'b0;
    logic xtal = 1'b1;
    scc_wake_t cmd_wake = '0;
    logic sleep_instr;
    scc_wake_t wake;
    logic [3:0] sel;
    logic tick, mon_off, mon_on, sleeping, hold, conv, resume, rvec;
    scc_clk_t clk_en;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    int conv_cnt = 0;
    logic [7:0] rnd = 8'h0E;
    logic [31:0] exp_q[$];
    logic [31:0] e;
    logic [2:0] modes[6] = '{MODE_IDLE, MODE_QUIET, MODE_PWR_DOWN, MODE_PWR_SAVE,
        MODE_STANDBY, MODE_EXT_STANDBY};
    int ns[6] = '{1, 1, 20, 20, 6, 6};

    always #10 i_sys_clk = ~i_sys_clk;

    scc_top #(.PD_STARTUP_CYCLES(20)) scc_top_inst (
        .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_divide_by_eight_fuse(fuse),
        .i_div_wr(div_wr), .i_div_wdata(div_wd), .i_sleep_allow(allow),
        .i_sleep_mode_select(mode), .i_sleep_instr(sleep_instr), .i_mcu_ctrl_wr(ctl_wr),
        .i_mcu_ctrl_wdata(ctl_wd), .i_mcu_ctrl_unlock(unlock), .i_crystal_clock(xtal),
        .i_timer2_async(t2a), .i_converter_enable(conv_en), .i_wake(wake),
        .o_clock_divider_select(sel), .o_div_tick(tick), .o_clk_en(clk_en),
        .o_monitor_sleep_off(mon_off), .o_monitor_on(mon_on), .o_sleeping(sleeping),
        .o_core_hold(hold), .o_start_conversion(conv), .o_resume(resume),
        .o_reset_vector(rvec));

    scc_core_model scc_core_model_inst (
        .i_sys_clk(i_sys_clk), .i_core_hold(hold), .i_cmd_sleep(cmd_sleep),
        .i_cmd_wake(cmd_wake), .o_sleep_instr(sleep_instr), .o_wake(wake));

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // Expected domain enables {core,flash,io,adc,asy,main_osc,timer_osc}
    function automatic logic [6:0] clk_exp(input logic [2:0] m, input logic t);
        case (m)
            MODE_IDLE: return {6'h0F, t};
            MODE_QUIET: return {6'h07, t};
            MODE_PWR_SAVE: return {4'h0, t, 1'b0, t};
            MODE_STANDBY: return 7'h02;
            MODE_EXT_STANDBY: return {4'h0, t, 1'b1, t};
            default: return 7'h00;
        endcase
    endfunction

    task automatic step();
        @(posedge i_sys_clk);
        #1;
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [15:0] g, input logic [15:0] x);
        n_checks++;
        if (g !== x) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, g, x);
        end
    endtask

    task automatic chk_evt(input logic [31:0] g, input logic [31:0] x);
        n_checks++;
        if (g !== x) begin
            err_count++;
            $display("[FAIL] %0t event %h exp %h", $time, g, x);
        end
    endtask

    task automatic tick_gap(output int g);
        int k;
        for (k = 0; k < 600 && tick !== 1'b1; k++) step();
        step();
        g = 1;
        while (tick !== 1'b1 && g < 600) begin
            step();
            g++;
        end
    endtask

    task automatic ctl_write(input logic [7:0] d, input logic u);
        ctl_wd = d;
        unlock = u;
        ctl_wr = 1'b1;
        step();
        ctl_wr = 1'b0;
        unlock = 1'b0;
        step();
    endtask

    task automatic do_sleep(input logic [2:0] m, input logic a, input scc_wake_t w,
            input int n, input logic mon);
        scc_wake_t bad;
        logic [30:0] tc;
        int k;
        bad = '0;
        bad.other_io = 1'b1;
        rnd = lfsr(rnd);
        t2a = rnd[0];
        conv_en = rnd[1];
        mode = m;
        allow = a;
        conv_cnt = 0;
        cmd_sleep = 1'b1;
        step();
        cmd_sleep = 1'b0;
        repeat (5) step();
        chk_val(sleeping, a);
        chk_val(clk_en, a ? clk_exp(m, t2a) : {4'hF, t2a, 1'b1, t2a});
        chk_val(mon_on, mon);
        chk_val(conv_cnt, a && conv_en && m < MODE_PWR_DOWN);
        if (a) begin
            // Sources outside the mode's wake list must leave it asleep
            if (m != MODE_IDLE) begin
                cmd_wake = bad;
                step();
                cmd_wake = '0;
                repeat (5) step();
                chk_val(sleeping, 1'b1);
            end
            cmd_wake = w;
            tc = cyc + n + 7;
            exp_q.push_back({w.ext_reset, tc});
            step();
            cmd_wake = '0;
            for (k = 0; k < n + 30 && hold !== 1'b0; k++) step();
            chk_val(mon_on, 1'b1);
            chk_val(clk_en, {4'hF, t2a, 1'b1, t2a});
            repeat (3) step();
        end
        allow = 1'b0;
    endtask

    // ****************************************
    // Watchers
    // ****************************************
    always @(posedge i_sys_clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            summarize();
        end
    end

    always @(posedge i_sys_clk) begin
        #1;
        if (conv === 1'b1) conv_cnt++;
        if (resume === 1'b1 || rvec === 1'b1) begin
            e = exp_q.size() > 0 ? exp_q.pop_front() : 32'hFFFFFFFF;
            chk_evt({rvec, cyc[30:0]}, e);
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        int s;
        int g;
        scc_wake_t w;
        repeat (4) step();
        chk_val({sleeping, hold, mon_on, clk_en}, {3'b001, 7'h7F});
        i_reset_n = 1'b1;
        step();
        chk_val(sel, DIV_SEL_RESET_DIV8);
        chk_val(mon_off, MON_SLEEP_OFF_RESET);
        fuse = 1'b0;
        i_reset_n = 1'b0;
        repeat (4) step();
        i_reset_n = 1'b1;
        chk_val(sel, DIV_SEL_RESET_PLAIN);
        for (s = 0; s < 10; s++) begin
            rnd = lfsr(rnd);
            fuse = rnd[0];
            div_wd = s[3:0];
            div_wr = 1'b1;
            step();
            div_wr = 1'b0;
            step();
            chk_val(sel, s[3:0]);
            tick_gap(g);
            tick_gap(g);
            chk_val(g, s > 8 ? 256 : 1 << s);
        end
        ctl_write(8'h40, 1'b0);
        chk_val(mon_off, 1'b0);
        w = '0;
        w.ext0_level = 1'b1;
        for (s = 0; s < 6; s++) do_sleep(modes[s], 1'b1, w, ns[s], 1'b1);
        do_sleep(MODE_IDLE, 1'b0, w, 1, 1'b1);
        ctl_write(8'h40, 1'b1);
        chk_val(mon_off, 1'b1);
        do_sleep(MODE_IDLE, 1'b1, w, 1, 1'b1);
        do_sleep(MODE_PWR_DOWN, 1'b1, w, 3000, 1'b0);
        ctl_write(8'h00, 1'b1);
        w = '0;
        w.ext_reset = 1'b1;
        do_sleep(MODE_STANDBY, 1'b1, w, 6, 1'b1);
        // Standby code 110 without a crystal source must not put the core to sleep
        xtal = 1'b0;
        mode = MODE_STANDBY;
        allow = 1'b1;
        cmd_sleep = 1'b1;
        step();
        cmd_sleep = 1'b0;
        repeat (3) step();
        chk_val(sleeping, 1'b0);
        allow = 1'b0;
        xtal = 1'b1;
        chk_val(exp_q.size(), 16'h0000);
        summarize();
    end
endmodule
